// ===== design/mac_top.sv
// modulo address correction in the data address path
`timescale 1ns/100ps
`include "mac_defs.svh"
// Functional notes
// [RL1] modulo usable on any pointer register
// [RL2] incrementing buffer: test against upper boundary
// [RL3] decrementing buffer: test against lower boundary
// [RL4] detect beyond boundary, not only equality
// [RL5] write back only for pre/post modify
// [RL6] offset mode corrects address, keeps pointer
// [RL7] fold back by exactly one buffer length
module mac_top
  import mac_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic REQ_VALID_IN,
  input wire logic [`MAC_SELW-1:0] REQ_PTR_SEL_IN,
  input wire logic [1:0] REQ_MODE_IN,
  input wire logic [`MAC_AW-1:0] REQ_STEP_IN,
  input wire logic MOD_EN_IN,
  input wire logic [`MAC_SELW-1:0] MOD_SEL_IN,
  input wire logic [`MAC_AW-1:0] BUF_START_IN,
  input wire logic [`MAC_AW-1:0] BUF_END_IN,
  input wire logic LOAD_VALID_IN,
  input wire logic [`MAC_SELW-1:0] LOAD_SEL_IN,
  input wire logic [`MAC_AW-1:0] LOAD_DATA_IN,
  input wire logic [`MAC_SELW-1:0] RD_SEL_IN,
  output logic ADDR_VALID_OUT,
  output logic [`MAC_AW-1:0] ADDR_OUT,
  output logic WRAP_OUT,
  output logic PTR_UPD_OUT,
  output logic [`MAC_AW-1:0] PTR_RD_OUT
);
  // ****************************************
  // state and datapath
  // ****************************************
  mac_state_t st;
  mac_state_t next_st;
  mac_mode_t mode;
  logic [`MAC_AW-1:0] sel_ptr;
  logic [`MAC_AW-1:0] sum_raw;
  logic [`MAC_AW-1:0] corr;
  logic mod_hit;
  logic fold;
  logic step_pos;

  assign mode = mac_mode_t'(REQ_MODE_IN);
  assign sel_ptr = st.ptr[REQ_PTR_SEL_IN];
  assign sum_raw = sel_ptr + REQ_STEP_IN;
  assign step_pos = ~REQ_STEP_IN[`MAC_AW-1];
  // any pointer index may be the modulo one
  assign mod_hit = MOD_EN_IN && (MOD_SEL_IN == REQ_PTR_SEL_IN); // RL1

  mac_fold u_fold (
    .en_in(mod_hit),
    .base_in(sel_ptr),
    .step_in(REQ_STEP_IN),
    .lo_in(BUF_START_IN),
    .hi_in(BUF_END_IN),
    .res_out(corr),
    .wrap_out(fold)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.valid = REQ_VALID_IN;
    next_st.wrap = 1'b0;
    next_st.upd = 1'b0;
    if (REQ_VALID_IN) begin
      case (mode)
        MAC_MODE_POST: begin
          next_st.addr = sel_ptr;
          next_st.ptr[REQ_PTR_SEL_IN] = corr; // RL5
          next_st.upd = 1'b1;
          next_st.wrap = fold;
        end
        MAC_MODE_PRE: begin
          next_st.addr = corr;
          next_st.ptr[REQ_PTR_SEL_IN] = corr; // RL5
          next_st.upd = 1'b1;
          next_st.wrap = fold;
        end
        MAC_MODE_OFFSET: begin
          // corrected address goes out, pointer left alone
          next_st.addr = corr; // RL6
          next_st.wrap = fold;
        end
        default: begin
          next_st.addr = sel_ptr;
        end
      endcase
    end
    // a direct load wins over a write-back to the same pointer
    if (LOAD_VALID_IN) begin
      next_st.ptr[LOAD_SEL_IN] = LOAD_DATA_IN;
    end
    next_st.rd = next_st.ptr[RD_SEL_IN];
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st.ptr <= '0;
      st.addr <= `MAC_ADDR_RST;
      st.valid <= 1'b0;
      st.wrap <= 1'b0;
      st.upd <= 1'b0;
      st.rd <= `MAC_PTR_RST;
    end else begin
      st <= next_st;
    end
  end

  assign ADDR_VALID_OUT = st.valid;
  assign ADDR_OUT = st.addr;
  assign WRAP_OUT = st.wrap;
  assign PTR_UPD_OUT = st.upd;
  assign PTR_RD_OUT = st.rd;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  logic corr_mode;
  assign corr_mode = (mode == MAC_MODE_PRE) || (mode == MAC_MODE_OFFSET);

  // a step longer than the buffer is folded once only, so the bound checks
  // hold only for a pointer inside the buffer and a step no longer than it
  logic [`MAC_AW-1:0] buf_len;
  logic [`MAC_AW-1:0] step_mag;
  logic ptr_in_buf;
  logic step_fits;
  logic load_clash;
  assign buf_len = BUF_END_IN - BUF_START_IN + `MAC_ONE;
  assign step_mag = step_pos ? REQ_STEP_IN : (~REQ_STEP_IN + `MAC_ONE);
  assign ptr_in_buf = (sel_ptr >= BUF_START_IN) && (sel_ptr <= BUF_END_IN);
  assign step_fits = (step_mag <= buf_len);
  // a same-cycle load overrides the write-back, so those checks skip it
  assign load_clash = LOAD_VALID_IN && (LOAD_SEL_IN == REQ_PTR_SEL_IN);

  sequence s_mod_req;
    REQ_VALID_IN && mod_hit && corr_mode;
  endsequence

  sequence s_inc_over;
    s_mod_req ##0 (step_pos && (sum_raw > BUF_END_IN));
  endsequence

  sequence s_dec_under;
    s_mod_req ##0 (!step_pos && (sum_raw < BUF_START_IN));
  endsequence

  a_any_pointer: assert property ( // RL1
    (REQ_VALID_IN && MOD_EN_IN && (MOD_SEL_IN == REQ_PTR_SEL_IN) && corr_mode && step_pos
      && (sum_raw > BUF_END_IN)) |=> ADDR_VALID_OUT && WRAP_OUT)
    else $error("modulo pointer overrun did not fold");

  a_inc_upper: assert property (s_inc_over ##0 (ptr_in_buf && step_fits) |=> // RL2
    ADDR_OUT <= $past(BUF_END_IN))
    else $error("incrementing fold left address above upper bound");

  a_dec_lower: assert property (s_dec_under ##0 (ptr_in_buf && step_fits) |=> // RL3
    ADDR_OUT >= $past(BUF_START_IN))
    else $error("decrementing fold left address below lower bound");

  a_no_fold_inside: assert property ( // RL4
    s_mod_req ##0 (sum_raw >= BUF_START_IN && sum_raw <= BUF_END_IN)
      |=> !WRAP_OUT && (ADDR_OUT == $past(sum_raw)))
    else $error("in-range address was altered");

  a_writeback_mode: assert property ( // RL5
    REQ_VALID_IN |=> PTR_UPD_OUT == ($past(mode) == MAC_MODE_PRE || $past(mode) == MAC_MODE_POST))
    else $error("pointer write-back flag wrong for mode");

  a_post_issue_old: assert property ( // RL5
    (REQ_VALID_IN && mode == MAC_MODE_POST) |=> ADDR_OUT == $past(sel_ptr) ##1 1'b1)
    else $error("post-modify issued a modified address");

  a_offset_keeps: assert property ( // RL6
    (REQ_VALID_IN && mode == MAC_MODE_OFFSET && !LOAD_VALID_IN)
      |=> st.ptr[$past(REQ_PTR_SEL_IN)] == $past(sel_ptr) && !PTR_UPD_OUT)
    else $error("offset mode changed the pointer");

  a_fold_length: assert property (s_inc_over |=> // RL7
    ADDR_OUT == $past(sum_raw) - ($past(BUF_END_IN) - $past(BUF_START_IN) + `MAC_ONE))
    else $error("fold distance is not one buffer length");

  a_dec_length: assert property (s_dec_under |=> // RL7
    ADDR_OUT == $past(sum_raw) + $past(buf_len))
    else $error("decrementing fold distance is not one buffer length");

  a_post_fold_len: assert property ( // RL7
    (REQ_VALID_IN && mode == MAC_MODE_POST && mod_hit && !load_clash && step_pos
      && (sum_raw > BUF_END_IN))
      |=> st.ptr[$past(REQ_PTR_SEL_IN)] == $past(sum_raw) - $past(buf_len))
    else $error("post-modify fold stored a wrong pointer");

  a_pre_stores: assert property ( // RL5
    (REQ_VALID_IN && mode == MAC_MODE_PRE && !load_clash)
      |=> st.ptr[$past(REQ_PTR_SEL_IN)] == ADDR_OUT)
    else $error("pre-modify did not store the issued address");

  a_post_stores: assert property ( // RL5
    (REQ_VALID_IN && mode == MAC_MODE_POST && !load_clash && !fold)
      |=> st.ptr[$past(REQ_PTR_SEL_IN)] == $past(sum_raw))
    else $error("post-modify did not store the stepped pointer");

  a_plain_passes: assert property ( // RL5
    (REQ_VALID_IN && mode == MAC_MODE_PLAIN)
      |=> !WRAP_OUT && !PTR_UPD_OUT && ADDR_OUT == $past(sel_ptr))
    else $error("plain mode altered the address or the pointer");

  a_no_mod_wrap: assert property ( // RL1
    (REQ_VALID_IN && !mod_hit) |=> !WRAP_OUT)
    else $error("fold reported for a pointer without modulo");

  a_valid_pulse: assert property ( // RL1
    1'b1 |=> ADDR_VALID_OUT == $past(REQ_VALID_IN))
    else $error("address valid does not follow the request");

endmodule : mac_top

// ===== common/mac_defs.svh
// constants for the modulo address correction block
`ifndef MAC_DEFS_SVH
`define MAC_DEFS_SVH
`define MAC_AW 16
`define MAC_NPTR 16
`define MAC_SELW 4
`define MAC_PTR_RST 16'h0000
`define MAC_ADDR_RST 16'h0000
`define MAC_ONE 16'h0001
`endif

// ===== common/mac_pkg.sv
// types shared by the modulo address correction block
`include "mac_defs.svh"
package mac_pkg;

  // addressing mode of one effective address request
  typedef enum logic [1:0] {
    MAC_MODE_PLAIN = 2'b00,
    MAC_MODE_POST = 2'b01,
    MAC_MODE_PRE = 2'b10,
    MAC_MODE_OFFSET = 2'b11
  } mac_mode_t;

  typedef struct packed {
    logic [`MAC_NPTR-1:0][`MAC_AW-1:0] ptr;
    logic [`MAC_AW-1:0] addr;
    logic valid;
    logic wrap;
    logic upd;
    logic [`MAC_AW-1:0] rd;
  } mac_state_t;

endpackage : mac_pkg

// ===== design/mac_fold.sv
// boundary test and fold-back of one computed address
`timescale 1ns/100ps
`include "mac_defs.svh"
module mac_fold
  import mac_pkg::*;
(
  input wire logic en_in,
  input wire logic [`MAC_AW-1:0] base_in,
  input wire logic [`MAC_AW-1:0] step_in,
  input wire logic [`MAC_AW-1:0] lo_in,
  input wire logic [`MAC_AW-1:0] hi_in,
  output logic [`MAC_AW-1:0] res_out,
  output logic wrap_out
);
  logic [`MAC_AW-1:0] sum;
  logic [`MAC_AW-1:0] len;
  logic inc;

  always_comb begin
    sum = base_in + step_in;
    len = hi_in - lo_in + `MAC_ONE;
    // sign of the step tells the buffer direction
    inc = ~step_in[`MAC_AW-1];
    res_out = sum;
    wrap_out = 1'b0;
    // range compare, not equality, so an overshooting step still folds
    if (en_in && inc && (sum > hi_in)) begin // RL2 RL4
      res_out = sum - len; // RL7
      wrap_out = 1'b1;
    end else if (en_in && !inc && (sum < lo_in)) begin // RL3 RL4
      res_out = sum + len; // RL7
      wrap_out = 1'b1;
    end
  end
endmodule : mac_fold

// ===== verif/mac_mem.sv
// data memory stand-in that counts the addresses it is given
`timescale 1ns/100ps
`include "mac_defs.svh"
module mac_mem
  import mac_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic valid_in,
  input wire logic [`MAC_AW-1:0] addr_in,
  output logic [15:0] count_out,
  output logic [`MAC_AW-1:0] last_out
);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_out <= 16'h0000;
      last_out <= 16'h0000;
    end else if (valid_in) begin
      count_out <= count_out + 16'h0001;
      last_out <= addr_in;
    end
  end
endmodule : mac_mem

// ===== verif/mac_top_bench.sv
// self-checking bench for the modulo address correction block
`timescale 1ns/100ps
`include "mac_defs.svh"
module mac_top_bench
  import mac_pkg::*;
;
  logic clk = 0, rst_n = 0, rv = 0, me = 0, lv = 0, av, wr, up;
  logic [3:0] ps = 0, ms = 0, ls = 0, rs = 0;
  logic [1:0] md = 0;
  logic [15:0] st = 0, bs = 16'h0100, be = 16'h011f, ld = 0, ao, pr, cnt, la = 0, lst;
  logic [15:0] p [16];
  logic [33:0] q [$];
  int mismatches = 0, n_checks = 0, seed = 76, cyc = 0, nreq = 0;
  mac_top mac_top_i (.CLK_IN(clk), .RST_N_IN(rst_n), .REQ_VALID_IN(rv), .REQ_PTR_SEL_IN(ps),
    .REQ_MODE_IN(md), .REQ_STEP_IN(st), .MOD_EN_IN(me), .MOD_SEL_IN(ms), .BUF_START_IN(bs),
    .BUF_END_IN(be), .LOAD_VALID_IN(lv), .LOAD_SEL_IN(ls), .LOAD_DATA_IN(ld), .RD_SEL_IN(rs),
    .ADDR_VALID_OUT(av), .ADDR_OUT(ao), .WRAP_OUT(wr), .PTR_UPD_OUT(up), .PTR_RD_OUT(pr));
  mac_mem mac_mem_i (.clk_in(clk), .rst_n_in(rst_n), .valid_in(av), .addr_in(ao),
    .count_out(cnt), .last_out(lst));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    n_checks++;
    if (e !== g) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // one load or request per cycle; the model keeps its own copy of the pointers
  task automatic op(input logic l, input logic [3:0] s, input logic [1:0] m,
      input logic [15:0] v, input logic e, input logic [3:0] k);
    logic [15:0] sum, c, np;
    logic w;
    sum = p[s] + v;
    c = sum;
    w = 0;
    if (e && s == k && m != MAC_MODE_PLAIN) begin
      if (!v[15] && sum > be) begin
        c = sum - (be - bs + 16'h0001);
        w = 1;
      end
      if (v[15] && sum < bs) begin
        c = sum + (be - bs + 16'h0001);
        w = 1;
      end
    end
    @(posedge clk);
    lv <= l; rv <= !l; ls <= s; ps <= s; rs <= s; md <= m; st <= v; ld <= v; me <= e; ms <= k;
    np = (m[0] ^ m[1]) ? c : p[s];
    if (l) p[s] = v;
    else begin
      la = m[1] ? c : p[s];
      q.push_back({la, w, m[0] ^ m[1], np});
      p[s] = np;
      nreq++;
    end
  endtask : op
  // ****************************************
  // checking and stimulus
  // ****************************************
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      tally_and_finish();
    end else if (av === 1'b1) begin
      if (q.size() == 0) chk("unexpected", 0, 1);
      else chk("result", q.pop_front(), {ao, wr, up, pr});
    end
  end
  initial begin
    logic [3:0] s;
    repeat (8) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 16; i++) op(1, i, 0, 16'h0100 + i, 1, 0);
    op(1, 3, 0, 16'h011e, 1, 3);
    op(0, 3, 2, 16'h0001, 1, 3);
    op(0, 3, 1, 16'h0001, 1, 3);
    op(0, 3, 3, 16'hfffe, 1, 3);
    for (int i = 0; i < 300; i++) begin
      s = 4'($random(seed));
      // wide steps overshoot the 32-word buffer
      op(i % 20 == 0, s, 2'($random(seed)), 16'($random(seed) % 41), i % 8 != 0,
        ($random(seed) & 1) ? s : ~s);
    end
    @(posedge clk);
    rv <= 0;
    lv <= 0;
    repeat (3) @(posedge clk);
    chk("accesses", 34'(nreq), 34'(cnt));
    chk("pending", 0, 34'(q.size()));
    chk("last address", 34'(la), 34'(lst));
    tally_and_finish();
  end
endmodule : mac_top_bench
